// [pmt_timer.sv]
// Period match timer with APB register slave and interrupt logic.
// Assumes an APB master on i_clk_sys; match output feeds PWM units only.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/10ps
module pmt_timer (
    input wire logic i_clk_sys, // System clock, 200 MHz
    input wire logic i_rst_n, // Async reset, active low
    input wire logic i_psel, // APB select
    input wire logic i_penable, // APB enable
    input wire logic i_pwrite, // APB write
    input wire logic [7:0] i_paddr, // APB byte address
    input wire logic [31:0] i_pwdata, // APB write data
    output logic [31:0] o_prdata, // APB read data
    output logic o_pready, // APB ready
    output logic o_pslverr, // APB error
    output logic o_pwm_timebase, // Match pulse to PWM units
    output logic o_irq, // Interrupt, level
    output logic o_irq_high_prio // Interrupt is high priority
);
    import pmt_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] ctrl_reg;
    logic [7:0] count_reg;
    logic [7:0] period_reg;
    logic [7:0] flag_reg;
    logic [7:0] enable_reg;
    logic [7:0] prio_reg;
    logic [7:0] gate_reg;
    logic [3:0] post_reg;
    logic tick;
    logic match;
    logic post_event;
    logic setup;
    logic wr;
    logic rd;
    logic hit;
    logic [7:0] rdata;

    // Address is one of the mapped registers
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == PMT_OFS_CTRL) || (a == PMT_OFS_COUNT) || (a == PMT_OFS_PERIOD)
               || (a == PMT_OFS_FLAG) || (a == PMT_OFS_ENABLE) || (a == PMT_OFS_PRIO)
               || (a == PMT_OFS_GATE);
    endfunction : addr_ok

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // Single wait-free access: answer in the first access cycle
    assign setup = i_psel && !i_penable;
    assign hit = addr_ok(i_paddr);
    assign wr = i_psel && i_penable && o_pready && i_pwrite && hit;
    assign rd = i_psel && i_penable && o_pready && !i_pwrite && hit;

    // Ready raised for the access phase that follows setup
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pready <= 1'b0;
        end else begin
            o_pready <= setup;
        end
    end

    // Error on unmapped address, in step with ready
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pslverr <= 1'b0;
        end else begin
            o_pslverr <= setup && !hit;
        end
    end

    // Read mux
    always_comb begin
        case (i_paddr)
            PMT_OFS_CTRL: rdata = ctrl_reg & PMT_CTRL_WMASK;
            PMT_OFS_COUNT: rdata = count_reg;
            PMT_OFS_PERIOD: rdata = period_reg;
            PMT_OFS_FLAG: rdata = flag_reg;
            PMT_OFS_ENABLE: rdata = enable_reg;
            PMT_OFS_PRIO: rdata = prio_reg;
            PMT_OFS_GATE: rdata = gate_reg;
            default: rdata = 8'h00;
        endcase
    end

    // Read data registered during setup so it is valid with ready
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h0000_0000;
        end else if (setup) begin
            o_prdata <= {24'h00_0000, rdata};
        end
    end

    // ----------------------------------------
    // Control and configuration registers
    // ----------------------------------------
    // control layout, bit 7 masked
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_reg <= PMT_CTRL_RST;
        end else if (wr && i_paddr == PMT_OFS_CTRL) begin
            ctrl_reg <= i_pwdata[7:0] & PMT_CTRL_WMASK;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            period_reg <= PMT_PERIOD_RST;
        end else if (wr && i_paddr == PMT_OFS_PERIOD) begin
            period_reg <= i_pwdata[7:0];
        end
    end

    // enable at bit 3, only that bit stored
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            enable_reg <= 8'h00;
        end else if (wr && i_paddr == PMT_OFS_ENABLE) begin
            enable_reg <= 8'h00;
            enable_reg[PMT_IRQ_BIT] <= i_pwdata[PMT_IRQ_BIT];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prio_reg <= 8'h00;
        end else if (wr && i_paddr == PMT_OFS_PRIO) begin
            prio_reg <= 8'h00;
            prio_reg[PMT_IRQ_BIT] <= i_pwdata[PMT_IRQ_BIT];
        end
    end

    // Peripheral gate and priority-level enable
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gate_reg <= 8'h00;
        end else if (wr && i_paddr == PMT_OFS_GATE) begin
            gate_reg <= {6'h00, i_pwdata[PMT_PLVL_BIT], i_pwdata[PMT_GATE_BIT]};
        end
    end

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    pmt_prescaler u_pre (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_run(ctrl_reg[PMT_RUN_BIT]),
        .i_sel(ctrl_reg[PMT_PRE_MSB:PMT_PRE_LSB]),
        .o_tick(tick)
    );

    // no tick while stopped, so no match
    assign match = tick && (count_reg == period_reg);

    // count up, wrap to zero after match
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_reg <= PMT_COUNT_RST;
        end else if (wr && i_paddr == PMT_OFS_COUNT) begin
            count_reg <= i_pwdata[7:0];
        end else if (match) begin
            count_reg <= PMT_COUNT_RST;
        end else if (tick) begin
            count_reg <= count_reg + 8'h01;
        end
    end

    // pre-postscaler match drives the PWM time base, not the postscaled event
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pwm_timebase <= 1'b0;
        end else begin
            o_pwm_timebase <= match;
        end
    end

    // Postscaler counts matches, 1:1 to 1:16
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            post_reg <= 4'h0;
        end else if (!ctrl_reg[PMT_RUN_BIT]) begin
            post_reg <= 4'h0;
        end else if (post_event) begin
            post_reg <= 4'h0;
        end else if (match) begin
            post_reg <= post_reg + 4'h1;
        end
    end

    assign post_event = match && (post_reg == ctrl_reg[PMT_POST_MSB:PMT_POST_LSB]);

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    // sticky flag at bit 3, set wins over read clear
    // Only bits already returned in the captured read word are cleared, so an
    // event that lands between setup and access is not lost
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flag_reg <= 8'h00;
        end else if (post_event) begin
            flag_reg[PMT_IRQ_BIT] <= 1'b1;
        end else if (rd && i_paddr == PMT_OFS_FLAG) begin
            flag_reg <= flag_reg & ~o_prdata[7:0];
        end
    end

    // gate needed unless priority levels enabled
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= flag_reg[PMT_IRQ_BIT] && enable_reg[PMT_IRQ_BIT]
                  && (gate_reg[PMT_PLVL_BIT] || gate_reg[PMT_GATE_BIT]);
        end
    end

    // Priority only matters with levels enabled
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq_high_prio <= 1'b0;
        end else begin
            o_irq_high_prio <= gate_reg[PMT_PLVL_BIT] && prio_reg[PMT_IRQ_BIT];
        end
    end
endmodule : pmt_timer

// [pmt_pkg.sv]
// Package for the period match timer: register offsets, field layout, reset values.
// Assumes a 32-bit APB register bus with one aligned word per register.
package pmt_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] PMT_OFS_CTRL = 8'h00;
    localparam logic [7:0] PMT_OFS_COUNT = 8'h04;
    localparam logic [7:0] PMT_OFS_PERIOD = 8'h08;
    localparam logic [7:0] PMT_OFS_FLAG = 8'h0C;
    localparam logic [7:0] PMT_OFS_ENABLE = 8'h10;
    localparam logic [7:0] PMT_OFS_PRIO = 8'h14;
    localparam logic [7:0] PMT_OFS_GATE = 8'h18;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int PMT_POST_LSB = 3;
    localparam int PMT_POST_MSB = 6;
    localparam int PMT_RUN_BIT = 2;
    localparam int PMT_PRE_LSB = 0;
    localparam int PMT_PRE_MSB = 1;
    localparam int PMT_IRQ_BIT = 3;
    localparam int PMT_GATE_BIT = 0;
    localparam int PMT_PLVL_BIT = 1;
    localparam logic [7:0] PMT_CTRL_WMASK = 8'h7F;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] PMT_PERIOD_RST = 8'hFF;
    localparam logic [7:0] PMT_COUNT_RST = 8'h00;
    localparam logic [7:0] PMT_CTRL_RST = 8'h00;
endpackage : pmt_pkg

// [pmt_prescaler.sv]
// Prescaler for the period match timer: emits a tick every 1, 4 or 16 cycles.
// Assumes a single clock; select comes from a register on the same clock.
`timescale 1ns/10ps
module pmt_prescaler (
    input wire logic i_clk_sys, // System clock
    input wire logic i_rst_n, // Async reset, active low
    input wire logic i_run, // Counter running
    input wire logic [1:0] i_sel, // Prescale select
    output logic o_tick // Increment strobe
);
    logic [3:0] div_reg;
    logic [3:0] limit;

    // Divide ratio minus one per select code
    always_comb begin
        case (i_sel)
            2'b00: limit = 4'h0;
            2'b01: limit = 4'h3;
            default: limit = 4'hF;
        endcase
    end

    // Divider counter, cleared while stopped
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_reg <= 4'h0;
        end else if (!i_run || div_reg >= limit) begin
            div_reg <= 4'h0;
        end else begin
            div_reg <= div_reg + 4'h1;
        end
    end

    assign o_tick = i_run && (div_reg >= limit);
endmodule : pmt_prescaler

// [pmt_pwm_model.sv]
// PWM unit model fed by the timer match pulse.
// Assumes one pulse per PWM period on the system clock.
`timescale 1ns/10ps
module pmt_pwm_model (
    input wire logic i_clk_sys, // Clock
    input wire logic i_rst_n, // Reset, active low
    input wire logic i_timebase, // Match pulse
    output logic [15:0] o_periods // Periods seen
);
    // PWM time base
    // Each match pulse starts a PWM period
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_periods <= 16'h0000;
        end else if (i_timebase) begin
            o_periods <= o_periods + 16'h0001;
        end
    end
endmodule : pmt_pwm_model

// [pmt_timer_sva.sv]
// Checker on the timer ports.
// Assumes one clock domain; bound at the foot.
`timescale 1ns/10ps
module pmt_timer_sva
    import pmt_pkg::*;
(
    input wire logic i_clk_sys, // Clock
    input wire logic i_rst_n, // Reset
    input wire logic i_psel, // Select
    input wire logic i_penable, // Enable
    input wire logic i_pwrite, // Write
    input wire logic [7:0] i_paddr, // Address
    input wire logic [31:0] i_pwdata, // Wdata
    input wire logic [31:0] o_prdata, // Rdata
    input wire logic o_pready, // Ready
    input wire logic o_pslverr, // Error
    input wire logic o_pwm_timebase, // Match
    input wire logic o_irq, // Irq
    input wire logic o_irq_high_prio // Prio
);
    logic run_reg, en_reg, gate_reg, lvl_reg;
    wire wr = i_psel && i_penable && o_pready && i_pwrite;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // Shadow run, enable and gate bits
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            run_reg <= 1'b0;
            en_reg <= 1'b0;
            gate_reg <= 1'b0;
            lvl_reg <= 1'b0;
        end else if (wr) begin
            if (i_paddr == PMT_OFS_CTRL) run_reg <= i_pwdata[PMT_RUN_BIT];
            if (i_paddr == PMT_OFS_ENABLE) en_reg <= i_pwdata[PMT_IRQ_BIT];
            if (i_paddr == PMT_OFS_GATE) gate_reg <= i_pwdata[PMT_GATE_BIT];
            if (i_paddr == PMT_OFS_GATE) lvl_reg <= i_pwdata[PMT_PLVL_BIT];
        end
    end
    ready_after_setup_a: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no ready after setup");
    ready_one_cycle_a: assert property (o_pready |=> !o_pready)
        else $error("ready too long");
    unmapped_err_a: assert property (o_pready && i_paddr > PMT_OFS_GATE |-> o_pslverr)
        else $error("no error on unmapped");
    upper_zero_a: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
        else $error("upper data bits set");
    ctrl_msb_zero_a: assert property (o_pready && i_paddr == PMT_OFS_CTRL |-> !o_prdata[7])
        else $error("control bit 7 set");
    irq_needs_enable_a: assert property (o_irq |-> $past(en_reg))
        else $error("irq while disabled");
    irq_needs_gate_a: assert property (o_irq |-> $past(gate_reg) || $past(lvl_reg))
        else $error("irq without gate");
    prio_needs_levels_a: assert property (o_irq_high_prio |-> $past(lvl_reg))
        else $error("priority without levels");
    match_needs_run_a: assert property (o_pwm_timebase |-> $past(run_reg) || $past(run_reg, 2))
        else $error("match while stopped");
    cover property (o_irq);
    cover property (o_pwm_timebase);
    cover property (o_pslverr);
endmodule : pmt_timer_sva
bind pmt_timer pmt_timer_sva u_pmt_timer_sva (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_pwm_timebase(o_pwm_timebase), .o_irq(o_irq), .o_irq_high_prio(o_irq_high_prio));

// [pmt_timer_tb.sv]
// Directed testbench for the timer over APB.
// Assumes the package, design, checker and PWM model.
`timescale 1ns/10ps
module pmt_timer_tb;
    import pmt_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic [31:0] o_prdata, rd, held;
    logic o_pready, o_pslverr, o_pwm_timebase, o_irq, o_irq_high_prio, err;
    logic [15:0] periods;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    int gap;
    int exp_gap[4] = '{4, 16, 64, 64};
    // Clock at 200 MHz
    always #2.5 i_clk_sys = ~i_clk_sys;
    pmt_timer u_pmt_timer (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .o_pwm_timebase(o_pwm_timebase), .o_irq(o_irq), .o_irq_high_prio(o_irq_high_prio));
    pmt_pwm_model u_pmt_pwm_model (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_timebase(o_pwm_timebase), .o_periods(periods));
    task automatic test_done;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // One APB transfer, held until ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        do @(posedge i_clk_sys); while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask : rchk
    // Cycles from one match pulse to the next
    task automatic measure;
        gap = 0;
        do @(posedge i_clk_sys); while (o_pwm_timebase !== 1'b1);
        do begin
            @(posedge i_clk_sys);
            gap++;
        end while (o_pwm_timebase !== 1'b1);
    endtask : measure
    // Hang guard
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            test_done;
        end
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        rchk("period_rst", PMT_OFS_PERIOD, 32'h0000_00FF);
        rchk("ctrl_rst", PMT_OFS_CTRL, 32'h0);
        rchk("count_rst", PMT_OFS_COUNT, 32'h0);
        apb(1'b1, PMT_OFS_PERIOD, 32'h1234_56A5);
        rchk("period_rw", PMT_OFS_PERIOD, 32'h0000_00A5);
        apb(1'b1, PMT_OFS_CTRL, 32'h0000_00FF);
        rchk("ctrl_msb", PMT_OFS_CTRL, 32'h0000_007F);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        chk("unmapped_data", 32'h0, rd);
        $display("test registers done");
        apb(1'b1, PMT_OFS_PERIOD, 32'h3);
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, PMT_OFS_CTRL, 32'h4 | p);
            measure;
            measure;
            chk("match_gap", exp_gap[p], gap);
        end
        apb(1'b1, PMT_OFS_CTRL, 32'h0);
        apb(1'b0, PMT_OFS_COUNT, 32'h0);
        held = rd;
        repeat (100) @(posedge i_clk_sys);
        rchk("count_hold", PMT_OFS_COUNT, held);
        chk("count_range", 32'h1, {31'h0, held <= 32'h3});
        chk("pwm_ran", 32'h1, {31'h0, periods != 16'h0});
        $display("test counting done");
        rchk("flag_pending", PMT_OFS_FLAG, 32'h8);
        apb(1'b1, PMT_OFS_ENABLE, 32'h8);
        apb(1'b1, PMT_OFS_GATE, 32'h1);
        chk("irq_idle", 32'h0, {31'h0, o_irq});
        apb(1'b1, PMT_OFS_CTRL, 32'h4);
        repeat (20) @(posedge i_clk_sys);
        apb(1'b1, PMT_OFS_CTRL, 32'h0);
        chk("irq_on", 32'h1, {31'h0, o_irq});
        apb(1'b1, PMT_OFS_ENABLE, 32'h0);
        repeat (2) @(posedge i_clk_sys);
        chk("irq_masked", 32'h0, {31'h0, o_irq});
        apb(1'b1, PMT_OFS_ENABLE, 32'h8);
        apb(1'b1, PMT_OFS_GATE, 32'h0);
        repeat (2) @(posedge i_clk_sys);
        chk("irq_gated", 32'h0, {31'h0, o_irq});
        chk("prio_off", 32'h0, {31'h0, o_irq_high_prio});
        apb(1'b1, PMT_OFS_PRIO, 32'h8);
        apb(1'b1, PMT_OFS_GATE, 32'h2);
        repeat (2) @(posedge i_clk_sys);
        chk("irq_levels", 32'h1, {31'h0, o_irq});
        chk("irq_prio", 32'h1, {31'h0, o_irq_high_prio});
        rchk("flag_set", PMT_OFS_FLAG, 32'h8);
        repeat (2) @(posedge i_clk_sys);
        chk("irq_cleared", 32'h0, {31'h0, o_irq});
        rchk("flag_clear", PMT_OFS_FLAG, 32'h0);
        $display("test interrupt done");
        // Postscale 3: flag stays clear for three matches, sets on the fourth
        apb(1'b1, PMT_OFS_CTRL, 32'h1F);
        repeat (3) do @(posedge i_clk_sys); while (o_pwm_timebase !== 1'b1);
        rchk("post_third", PMT_OFS_FLAG, 32'h0);
        do @(posedge i_clk_sys); while (o_pwm_timebase !== 1'b1);
        rchk("post_fourth", PMT_OFS_FLAG, 32'h8);
        apb(1'b1, PMT_OFS_CTRL, 32'h0);
        $display("test postscale done");
        test_done;
    end
endmodule : pmt_timer_tb
